// ### qdac_regs.vh
/*
 * constants of the quad converter serial load block: frame layout,
 * register select and channel codes, bus register offsets and fields.
 * assumes inclusion by bare name from the design and monitor files.
 */
`ifndef QDAC_REGS_VH
`define QDAC_REGS_VH

// frame layout
`define QDAC_FRAME_BITS 24
`define QDAC_CNT_W 5
`define QDAC_CNT_FULL 5'h18
`define QDAC_CNT_OVER 5'h19
`define QDAC_RW_BIT 23
`define QDAC_RSV_BIT 22
`define QDAC_REG_HI 21
`define QDAC_REG_LO 19
`define QDAC_ADR_HI 18
`define QDAC_ADR_LO 16
`define QDAC_DATA_HI 15
`define QDAC_CODE_LO 2

// register select codes
`define QDAC_REG_FUNC 3'h0
`define QDAC_REG_DATA 3'h2
`define QDAC_REG_CGAIN 3'h3
`define QDAC_REG_FGAIN 3'h4

// channel address codes, and function codes under register select 0
`define QDAC_ADR_ALL 3'h4
`define QDAC_FN_NOP 3'h0
`define QDAC_FN_CTRL 3'h1
`define QDAC_FN_CLEAR 3'h4
`define QDAC_FN_LOAD 3'h5

// field widths and values
`define QDAC_CODE_W 14
`define QDAC_CLEAR_CODE 14'h0000
`define QDAC_MSB_FLIP 14'h2000
`define QDAC_FGAIN_W 6
`define QDAC_CGAIN_W 2
`define QDAC_FUNC_W 6
`define QDAC_FUNC_SDO_OFF 0

// bus registers (byte offsets)
`define QDAC_A_CTRL 5'h00
`define QDAC_A_STATUS 5'h04
`define QDAC_A_FUNC 5'h08
`define QDAC_A_CODE0 5'h10
`define QDAC_CTRL_CHAIN 0
`define QDAC_ST_CLAMP 0
`define QDAC_ST_BAD 1
`define QDAC_ST_SDO_OFF 2
`define QDAC_ST_CNT_LO 8

`endif

// ### qdac_serial.v
/*
 * serial front end and output update control of a quad 14-bit converter:
 * 24-bit frame capture, daisy chain, readback, load and clear control.
 * assumes sys_clk_i (125 MHz) is well above the serial clock rate, so each
 * serial clock phase lasts at least two system cycles; all pins are
 * asynchronous and pass a two-flop synchroniser before use.
 */
// The register addresses and the Avalon-MM register port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "qdac_regs.vh"

module qdac_serial #(
  parameter CODE_W = `QDAC_CODE_W
) (
  // clock and reset
  input wire sys_clk_i,
  input wire rstn_i,
  // serial link pins
  input wire serial_clk_i,
  input wire frame_sync_n_i,
  input wire serial_data_in_i,
  output wire serial_data_out_o,
  output wire serial_data_out_oe_o,
  // control pins
  input wire load_outputs_n_i,
  input wire clear_outputs_n_i,
  input wire coding_select_i,
  // converter side
  output wire [4*CODE_W-1:0] dac_code_o,
  output wire outputs_clamped_o,
  output wire [`QDAC_FUNC_W-1:0] func_bits_o,
  // avalon-mm slave
  input wire [4:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  output wire [31:0] avs_readdata_o,
  output wire avs_waitrequest_o
);

  // channel select: mask of channels an address reaches (one, all four, or none)
  function [3:0] chan_mask;
    input [2:0] adr;
    begin
      case (adr)
        3'h0: chan_mask = 4'h1;
        3'h1: chan_mask = 4'h2;
        3'h2: chan_mask = 4'h4;
        3'h3: chan_mask = 4'h8;
        `QDAC_ADR_ALL: chan_mask = 4'hF;
        // reserved addresses reach no channel, so such a frame writes nothing
        default: chan_mask = 4'h0;
      endcase
    end
  endfunction

  // offset-binary view of a stored code
  function [CODE_W-1:0] to_offset;
    input [CODE_W-1:0] code;
    input twos;
    begin
      to_offset = twos ? (code ^ `QDAC_MSB_FLIP) : code;
    end
  endfunction

  // synchronisers: first stage read only by second stage; coding resets
  // high, so codes read as offset binary until the pin has passed through
  reg [5:0] meta_ff;
  reg [5:0] pin_ff;
  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_ff <= 6'h3B;
      pin_ff <= 6'h3B;
    end else begin
      meta_ff <= {coding_select_i, clear_outputs_n_i, load_outputs_n_i,
                  serial_data_in_i, frame_sync_n_i, serial_clk_i};
      pin_ff <= meta_ff;
    end
  end

  wire sclk_s = pin_ff[0];
  wire sync_n_s = pin_ff[1];
  wire serial_data_in_s = pin_ff[2];
  wire load_n_s = pin_ff[3];
  wire clear_n_s = pin_ff[4];
  wire coding_s = pin_ff[5];

  // previous levels for edge detection; clear starts high so a pin held
  // low through power-up is seen as a falling edge
  reg sclk_d_ff;
  reg sync_d_ff;
  reg load_d_ff;
  reg clear_d_ff;
  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sclk_d_ff <= 1'b1;
      sync_d_ff <= 1'b1;
      load_d_ff <= 1'b1;
      clear_d_ff <= 1'b1;
    end else begin
      sclk_d_ff <= sclk_s;
      sync_d_ff <= sync_n_s;
      load_d_ff <= load_n_s;
      clear_d_ff <= clear_n_s;
    end
  end

  wire sclk_fall = sclk_d_ff & ~sclk_s;
  wire sclk_rise = ~sclk_d_ff & sclk_s;
  wire sync_fall = sync_d_ff & ~sync_n_s;
  wire sync_rise = ~sync_d_ff & sync_n_s;
  wire load_fall = load_d_ff & ~load_n_s;
  wire clear_fall = clear_d_ff & ~clear_n_s;
  wire in_frame = ~sync_n_s & ~sync_d_ff;

  // shift register, bit counter, serial out
  reg [`QDAC_FRAME_BITS-1:0] shift_ff;
  reg [`QDAC_CNT_W-1:0] cnt_ff;
  reg sdo_ff;
  reg load_low_ff;
  reg rb_pend_ff;
  reg [`QDAC_FRAME_BITS-1:0] rb_word_ff;

  // software registers and status
  reg chain_ff;
  reg bad_ff;
  reg [7:0] frames_ff;
  reg [`QDAC_FUNC_W-1:0] func_ff;
  reg clamp_ff;

  // per-channel storage
  reg [CODE_W-1:0] in_code_ff [0:3];
  reg [CODE_W-1:0] dac_ff [0:3];
  reg [`QDAC_CGAIN_W-1:0] cgain_ff [0:3];
  reg [`QDAC_FGAIN_W-1:0] fgain_ff [0:3];

  // frame decode
  wire rw_bit = shift_ff[`QDAC_RW_BIT];
  wire [2:0] reg_sel = shift_ff[`QDAC_REG_HI:`QDAC_REG_LO];
  wire [2:0] adr_sel = shift_ff[`QDAC_ADR_HI:`QDAC_ADR_LO];
  wire [15:0] data_f = shift_ff[`QDAC_DATA_HI:0];
  wire [3:0] mask = chan_mask(adr_sel);
  // a chained device keeps the last 24 bits, a lone one needs exactly 24
  wire cnt_ok = (cnt_ff == `QDAC_CNT_FULL) |
                (chain_ff & (cnt_ff == `QDAC_CNT_OVER));
  wire frame_ok = sync_rise & cnt_ok;
  wire do_write = frame_ok & ~rw_bit;
  wire do_read = frame_ok & rw_bit;
  wire is_func = (reg_sel == `QDAC_REG_FUNC);
  wire sw_clear = do_write & is_func & (adr_sel == `QDAC_FN_CLEAR);
  wire sw_load = do_write & is_func & (adr_sel == `QDAC_FN_LOAD);
  wire wr_ctrl = do_write & is_func & (adr_sel == `QDAC_FN_CTRL);
  wire wr_data = do_write & (reg_sel == `QDAC_REG_DATA);
  wire wr_cgain = do_write & (reg_sel == `QDAC_REG_CGAIN);
  wire wr_fgain = do_write & (reg_sel == `QDAC_REG_FGAIN);
  wire any_clear = clear_fall | sw_clear;
  // load pin low at the last clock fall of the frame: addressed channel goes straight through
  wire direct_upd = wr_data & load_low_ff;
  // load fall outside a frame updates every channel together
  wire all_upd = (load_fall & sync_n_s) | sw_load;

  // readback selection of the register named in a read request
  // address 100 reads channel A: only the low two address bits index
  reg [15:0] rb_data;
  always @* begin
    rb_data = 16'h0000;
    case (reg_sel)
      `QDAC_REG_FUNC:
        rb_data[`QDAC_FUNC_W-1:0] = func_ff;
      `QDAC_REG_DATA:
        rb_data[`QDAC_DATA_HI:`QDAC_CODE_LO] = in_code_ff[adr_sel[1:0]];
      `QDAC_REG_CGAIN:
        rb_data[`QDAC_CGAIN_W-1:0] = cgain_ff[adr_sel[1:0]];
      `QDAC_REG_FGAIN:
        rb_data[`QDAC_FGAIN_W-1:0] = fgain_ff[adr_sel[1:0]];
      default:
        rb_data = 16'h0000;
    endcase
  end

  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      shift_ff <= {`QDAC_FRAME_BITS{1'b0}};
      cnt_ff <= {`QDAC_CNT_W{1'b0}};
      sdo_ff <= 1'b0;
      load_low_ff <= 1'b0;
      rb_pend_ff <= 1'b0;
      rb_word_ff <= {`QDAC_FRAME_BITS{1'b0}};
    end else begin
      if (sync_fall) begin
        cnt_ff <= {`QDAC_CNT_W{1'b0}};
        // a pending readback word is what the new frame shifts out
        if (rb_pend_ff) begin
          shift_ff <= rb_word_ff;
          sdo_ff <= rb_word_ff[`QDAC_FRAME_BITS-1];
        end else begin
          sdo_ff <= shift_ff[`QDAC_FRAME_BITS-1];
        end
        rb_pend_ff <= 1'b0;
        load_low_ff <= ~load_n_s;
      end else if (in_frame) begin
        if (sclk_fall) begin
          shift_ff <= {shift_ff[`QDAC_FRAME_BITS-2:0], serial_data_in_s};
          if (cnt_ff != `QDAC_CNT_OVER)
            cnt_ff <= cnt_ff + 1'b1;
          // the load level at the last fall decides direct or batch update
          load_low_ff <= ~load_n_s;
        end
        if (sclk_rise)
          sdo_ff <= shift_ff[`QDAC_FRAME_BITS-1];
      end
      if (do_read) begin
        rb_pend_ff <= 1'b1;
        rb_word_ff <= {8'h00, rb_data};
      end
    end
  end

  // output-off bit resets clear; serial out is driven only while clear
  assign serial_data_out_o = sdo_ff;
  assign serial_data_out_oe_o = ~func_ff[`QDAC_FUNC_SDO_OFF];

  // per-channel registers
  integer i;
  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (i = 0; i < 4; i = i + 1) begin
        in_code_ff[i] <= `QDAC_CLEAR_CODE;
        dac_ff[i] <= `QDAC_CLEAR_CODE;
        cgain_ff[i] <= {`QDAC_CGAIN_W{1'b0}};
        fgain_ff[i] <= {`QDAC_FGAIN_W{1'b0}};
      end
    end else begin
      for (i = 0; i < 4; i = i + 1) begin
        if (any_clear) begin
          // clear wins over a load in the same cycle, and it also resets
          // the input side so a later load cannot bring back the old code
          in_code_ff[i] <= `QDAC_CLEAR_CODE;
          dac_ff[i] <= `QDAC_CLEAR_CODE;
        end else begin
          if (wr_data & mask[i])
            in_code_ff[i] <= data_f[`QDAC_DATA_HI:`QDAC_CODE_LO];
          if (direct_upd & mask[i])
            dac_ff[i] <= data_f[`QDAC_DATA_HI:`QDAC_CODE_LO];
          else if (all_upd)
            dac_ff[i] <= in_code_ff[i];
        end
        if (wr_cgain & mask[i])
          cgain_ff[i] <= data_f[`QDAC_CGAIN_W-1:0];
        if (wr_fgain & mask[i])
          fgain_ff[i] <= data_f[`QDAC_FGAIN_W-1:0];
      end
    end
  end

  // clamp holds from power-up until the first load or clear
  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i)
      clamp_ff <= 1'b1;
    else if (any_clear | all_upd | direct_upd)
      clamp_ff <= 1'b0;
  end

  // stored codes go out as offset binary so level tracks code/16384
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_out
      assign dac_code_o[g*CODE_W +: CODE_W] =
        to_offset(dac_ff[g], ~coding_s);
    end
  endgenerate
  assign outputs_clamped_o = clamp_ff;
  assign func_bits_o = func_ff;

  // avalon slave: one wait state per access
  reg ack_ff;
  reg [31:0] rdata_ff;
  wire req = avs_read_i | avs_write_i;
  wire take = req & ~ack_ff;
  // a write acts only at the edge one cycle after the wait state ends, where the
  // transfer completes on the bus; earlier the master may still settle
  wire wr_take = avs_write_i & ack_ff;
  wire bad_clr = wr_take & (avs_address_i == `QDAC_A_STATUS) &
                 avs_writedata_i[`QDAC_ST_BAD];

  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h0000_0000;
    case (avs_address_i)
      `QDAC_A_CTRL:
        rd_mux[`QDAC_CTRL_CHAIN] = chain_ff;
      `QDAC_A_STATUS: begin
        rd_mux[`QDAC_ST_CLAMP] = clamp_ff;
        rd_mux[`QDAC_ST_BAD] = bad_ff;
        rd_mux[`QDAC_ST_SDO_OFF] = func_ff[`QDAC_FUNC_SDO_OFF];
        rd_mux[`QDAC_ST_CNT_LO +: 8] = frames_ff;
      end
      `QDAC_A_FUNC:
        rd_mux[`QDAC_FUNC_W-1:0] = func_ff;
      `QDAC_A_CODE0, `QDAC_A_CODE0 + 5'h04, `QDAC_A_CODE0 + 5'h08,
      `QDAC_A_CODE0 + 5'h0C:
        rd_mux[CODE_W-1:0] = dac_code_o[avs_address_i[3:2]*CODE_W +: CODE_W];
      default:
        rd_mux = 32'h0000_0000;
    endcase
  end

  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ack_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      chain_ff <= 1'b0;
    end else begin
      ack_ff <= take;
      if (avs_read_i & take)
        rdata_ff <= rd_mux;
      if (wr_take & (avs_address_i == `QDAC_A_CTRL))
        chain_ff <= avs_writedata_i[`QDAC_CTRL_CHAIN];
    end
  end

  assign avs_waitrequest_o = req & ~ack_ff;
  assign avs_readdata_o = rdata_ff;

  // status: invalid-frame flag (set beats clear), frame counter, control
  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      bad_ff <= 1'b0;
      frames_ff <= 8'h00;
      func_ff <= {`QDAC_FUNC_W{1'b0}};
    end else begin
      if (sync_rise & ~cnt_ok)
        bad_ff <= 1'b1;
      else if (bad_clr)
        bad_ff <= 1'b0;
      if (frame_ok)
        frames_ff <= frames_ff + 8'h01;
      if (wr_ctrl)
        func_ff <= data_f[`QDAC_FUNC_W-1:0];
    end
  end

endmodule // qdac_serial
`default_nettype wire

// ### qdac_monitor.sv
/*
 * port checker for qdac_serial, bound to every instance.
 * assumes the pins are driven in step with sys_clk_i.
 */
`timescale 1ns/10ps
`default_nettype none
`include "qdac_regs.vh"
module qdac_monitor #(
  parameter CODE_W = 14
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // pins
  input wire logic serial_clk_i,
  input wire logic frame_sync_n_i,
  input wire logic load_outputs_n_i,
  input wire logic clear_outputs_n_i,
  input wire logic coding_select_i,
  input wire logic serial_data_out_o,
  input wire logic serial_data_out_oe_o,
  // converter side
  input wire logic [4*CODE_W-1:0] dac_code_o,
  input wire logic outputs_clamped_o,
  input wire logic [`QDAC_FUNC_W-1:0] func_bits_o,
  // bus
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o
);
  // cycles since a pin event; pins pass a synchroniser, so allow slack
  logic [3:0] upd_ff;
  logic [3:0] sdo_ff;
  wire req = avs_read_i | avs_write_i;
  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      upd_ff <= 4'h0;
      sdo_ff <= 4'h0;
    end else begin
      if ($rose(frame_sync_n_i) || $fell(load_outputs_n_i) ||
          $fell(clear_outputs_n_i) || $changed(coding_select_i))
        upd_ff <= 4'h0;
      else
        upd_ff <= upd_ff + {3'h0, upd_ff != 4'hF};
      if ($rose(serial_clk_i) || $changed(frame_sync_n_i))
        sdo_ff <= 4'h0;
      else
        sdo_ff <= sdo_ff + {3'h0, sdo_ff != 4'hF};
    end
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  sequence s_one_wait;
    avs_waitrequest_o ##1 !avs_waitrequest_o;
  endsequence
  a_one_wait: assert property ($rose(req) |-> s_one_wait)
    else $error("bus answer not after one wait state");
  a_idle_free: assert property (!req |-> !avs_waitrequest_o)
    else $error("waitrequest high while idle");
  a_rdata_hold: assert property ($changed(avs_readdata_o) |-> $past(avs_read_i))
    else $error("read data changed without a read");
  a_oe_func: assert property (
    !$changed(func_bits_o[0]) |-> serial_data_out_oe_o == !func_bits_o[0])
    else $error("serial out enable does not follow output-off bit");
  a_code_cause: assert property (
    $changed(dac_code_o) |-> upd_ff < 4'h8)
    else $error("output code changed with no update event");
  a_func_cause: assert property ($changed(func_bits_o) |-> upd_ff < 4'h8)
    else $error("function bits changed with no frame end");
  a_clamp_keep: assert property (!outputs_clamped_o |=> !outputs_clamped_o)
    else $error("clamp came back without reset");
  a_clamp_cause: assert property ($fell(outputs_clamped_o) |-> upd_ff < 4'h8)
    else $error("clamp released with no update event");
  a_sdo_edge: assert property (
    $changed(serial_data_out_o) |-> sdo_ff < 4'h8)
    else $error("serial out changed away from a clock rise");
endmodule // qdac_monitor
bind qdac_serial qdac_monitor #(.CODE_W(CODE_W)) qdac_monitor_i (
  .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .serial_clk_i(serial_clk_i),
  .frame_sync_n_i(frame_sync_n_i), .load_outputs_n_i(load_outputs_n_i),
  .clear_outputs_n_i(clear_outputs_n_i), .coding_select_i(coding_select_i),
  .serial_data_out_o(serial_data_out_o),
  .serial_data_out_oe_o(serial_data_out_oe_o), .dac_code_o(dac_code_o),
  .outputs_clamped_o(outputs_clamped_o), .func_bits_o(func_bits_o),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o));
`default_nettype wire

// ### qdac_host.sv
/*
 * host serial port model: 64 ns gated serial clock, idle high.
 * assumes sys_clk_i at 8 ns; pins change only after its rising edge.
 */
`timescale 1ns/10ps
`default_nettype none
module qdac_host (
  // system clock
  input wire logic sys_clk_i,
  // link
  input wire logic serial_data_out_i,
  output var logic serial_clk_o,
  output var logic frame_sync_n_o,
  output var logic serial_data_in_o
);
  initial begin
    serial_clk_o = 1'b1;
    frame_sync_n_o = 1'b1;
    serial_data_in_o = 1'b0;
  end
  // sends w[n-1:0] msb first; serial out is taken late in the low phase,
  // where it is still the bit that was valid at the fall
  task automatic xfer(input logic [47:0] w, input integer n,
                      output logic [47:0] rd);
    integer k;
    begin
      rd = 48'h0;
      @(posedge sys_clk_i);
      frame_sync_n_o <= 1'b0;
      for (k = n - 1; k >= 0; k = k - 1) begin
        serial_data_in_o <= w[k];
        repeat (4) @(posedge sys_clk_i);
        serial_clk_o <= 1'b0;
        repeat (4) @(posedge sys_clk_i);
        rd = {rd[46:0], serial_data_out_i};
        serial_clk_o <= 1'b1;
      end
      repeat (4) @(posedge sys_clk_i);
      frame_sync_n_o <= 1'b1;
      serial_data_in_o <= ~w[0];
      repeat (8) @(posedge sys_clk_i);
    end
  endtask
endmodule // qdac_host
`default_nettype wire

// ### testbench.sv
/*
 * self-checking bench for qdac_serial with the host model.
 * assumes the 125 MHz clock and twos complement coding at start.
 */
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin checked = checked + 1; if ((g) !== (e)) begin \
  error_cnt = error_cnt + 1; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module testbench;
  logic sys_clk_i, rstn_i, load_n, clear_n, coding, rd_i, wr_i;
  logic sclk, sync_n, serial_data_in, serial_data_out, sdo_oe, clamped, wait_o;
  logic [4:0] adr;
  logic [31:0] wdata, rdata, q;
  logic [55:0] code;
  logic [5:0] func;
  logic [47:0] rd;
  integer error_cnt = 0;
  integer checked = 0;
  integer cyc = 0;
  qdac_serial qdac_serial_i (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
    .serial_clk_i(sclk), .frame_sync_n_i(sync_n), .serial_data_in_i(serial_data_in),
    .serial_data_out_o(serial_data_out), .serial_data_out_oe_o(sdo_oe),
    .load_outputs_n_i(load_n), .clear_outputs_n_i(clear_n),
    .coding_select_i(coding), .dac_code_o(code), .outputs_clamped_o(clamped),
    .func_bits_o(func), .avs_address_i(adr), .avs_read_i(rd_i),
    .avs_write_i(wr_i), .avs_writedata_i(wdata), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wait_o));
  // a disabled serial out shows the inverse, so reading it fails loudly
  qdac_host qdac_host_i (.sys_clk_i(sys_clk_i),
    .serial_data_out_i(sdo_oe ? serial_data_out : ~serial_data_out),
    .serial_clk_o(sclk), .frame_sync_n_o(sync_n), .serial_data_in_o(serial_data_in));
  initial begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end
  task report_and_stop;
    begin
      $display("checked %0d error_cnt %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  // a whole run needs some 3800 cycles
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt = error_cnt + 1;
      report_and_stop;
    end
  end
  task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    begin
      @(posedge sys_clk_i);
      adr <= a;
      wr_i <= w;
      rd_i <= !w;
      wdata <= d;
      @(posedge sys_clk_i);
      // only the bench timeout ends a wait that never comes
      while (wait_o !== 1'b0)
        @(posedge sys_clk_i);
      q = rdata;
      rd_i <= 1'b0;
      wr_i <= 1'b0;
    end
  endtask
  task frame(input logic [23:0] w);
    qdac_host_i.xfer({24'h0, w}, 24, rd);
  endtask
  task settle;
    repeat (8) @(posedge sys_clk_i);
  endtask
  task t_reset;
    begin
      // coding pin needs its synchroniser before codes show twos view
      settle;
      `CHK("code", {4{14'h2000}}, code)
      `CHK("clamp", 1'b1, clamped)
      `CHK("oe", 1'b1, sdo_oe)
      bus(1'b0, 5'h04, 32'h0);
      `CHK("status", 32'h1, q)
    end
  endtask
  task t_direct;
    begin
      load_n <= 1'b0;
      frame(24'h148000);
      frame(24'h10ABCC);
      `CHK("direct", {42'h0, 14'h0AF3}, code)
      `CHK("unclamp", 1'b0, clamped)
    end
  endtask
  task t_batch;
    begin
      load_n <= 1'b1;
      frame(24'h114000);
      `CHK("b held", 14'h0000, code[27:14])
      load_n <= 1'b0;
      settle;
      `CHK("b", 14'h3000, code[27:14])
      load_n <= 1'b1;
      frame(24'h120004);
      frame(24'h050000);
      `CHK("c", 14'h2001, code[41:28])
    end
  endtask
  task t_bad;
    begin
      load_n <= 1'b0;
      qdac_host_i.xfer(48'h120008, 23, rd);
      qdac_host_i.xfer(48'h120008, 25, rd);
      `CHK("c kept", 14'h2001, code[41:28])
      bus(1'b0, 5'h04, 32'h0);
      `CHK("bad flag", 1'b1, q[1])
      bus(1'b1, 5'h04, 32'h2);
      bus(1'b0, 5'h04, 32'h0);
      `CHK("flag off", 1'b0, q[1])
      bus(1'b0, 5'h0C, 32'h0);
      `CHK("unmapped", 32'h0, q)
    end
  endtask
  task t_read;
    begin
      frame(24'h900000);
      frame(24'h000000);
      `CHK("rb data", 24'h00ABCC, rd[23:0])
      frame(24'h20FFEA);
      frame(24'hA00000);
      frame(24'h000000);
      `CHK("rb fine", 24'h00002A, rd[23:0])
      frame(24'h010001);
      `CHK("oe off", 1'b0, sdo_oe)
      `CHK("func", 6'h01, func)
      frame(24'h010000);
    end
  endtask
  task t_chain;
    begin
      bus(1'b1, 5'h00, 32'h1);
      qdac_host_i.xfer(48'h13001012000C, 48, rd);
      `CHK("ripple", 24'h130010, rd[23:0])
      `CHK("chain cd", {14'h0000, 14'h2003}, code[55:28])
      bus(1'b1, 5'h00, 32'h0);
    end
  endtask
  task t_clear;
    begin
      clear_n <= 1'b0;
      settle;
      `CHK("clr", {4{14'h2000}}, code)
      clear_n <= 1'b1;
      settle;
      `CHK("clr kept", {4{14'h2000}}, code)
      frame(24'h104000);
      frame(24'h040000);
      `CHK("sw clr", {4{14'h2000}}, code)
      coding <= 1'b1;
      settle;
      `CHK("offset", 56'h0, code)
    end
  endtask
  task t_power_clear;
    begin
      rstn_i <= 1'b0;
      clear_n <= 1'b0;
      coding <= 1'b0;
      settle;
      `CHK("rst clamp", 1'b1, clamped)
      rstn_i <= 1'b1;
      settle;
      `CHK("pwr clr", {4{14'h2000}}, code)
      `CHK("pwr unclamp", 1'b0, clamped)
      clear_n <= 1'b1;
      settle;
    end
  endtask
  initial begin
    rstn_i = 1'b0;
    load_n = 1'b1;
    clear_n = 1'b1;
    coding = 1'b0;
    rd_i = 1'b0;
    wr_i = 1'b0;
    adr = 5'h00;
    wdata = 32'h0;
    repeat (8) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    t_reset;
    t_direct;
    t_batch;
    t_bad;
    t_read;
    t_chain;
    t_clear;
    t_power_clear;
    report_and_stop;
  end
endmodule // testbench
`default_nettype wire
